// >>> core/wake_timer_pkg.sv
package wake_timer_pkg;
  // placement in the controller's internal address space
  localparam logic [31:0] BLOCK_BASE = 32'h0000_9800;
  localparam logic [31:0] OFS_PRELOAD = 32'h0000_0000;
  localparam logic [31:0] OFS_CONTROL = 32'h0000_0004;
  localparam logic [31:0] OFS_COUNT = 32'h0000_0008;
  // field layout and reset values
  localparam int CNT_W = 16;
  localparam int CTRL_COARSE_BIT = 0;
  localparam logic [CNT_W-1:0] PRELOAD_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // timing: figures in their own unit, cycles derived from the clock period
  localparam int CLK_PERIOD_NS = 10;
  localparam int FINE_TICK_NS = 30500;
  localparam int COARSE_TICK_MS = 125;
  localparam int FINE_TICK_CYCLES = FINE_TICK_NS / CLK_PERIOD_NS;
  localparam int COARSE_TICK_CYCLES = COARSE_TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DIV_W = 24;
  localparam logic [DIV_W-1:0] DIV_ZERO = 24'h00_0000;
  localparam logic [DIV_W-1:0] DIV_ONE = 24'h00_0001;
  // one-hot timer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } timer_state_t;
endpackage

// >>> core/tick_if.sv
`timescale 1ns/1ps
interface tick_if;
  logic restart;
  logic coarse;
  logic tick;
  modport timer (output restart, output coarse, input tick);
  modport prescaler (input restart, input coarse, output tick);
endinterface

// >>> core/tick_prescaler.sv
`timescale 1ns/1ps
module tick_prescaler
  import wake_timer_pkg::*;
#(
  parameter int COARSE_CYCLES = COARSE_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // tick request and answer
  tick_if.prescaler tk
);
  logic [DIV_W-1:0] divCount_reg, divCount_next;
  logic tick_reg, tick_next;
  logic [DIV_W-1:0] limit;

  assign limit = tk.coarse ? DIV_W'(COARSE_CYCLES) : DIV_W'(FINE_TICK_CYCLES);
  assign tk.tick = tick_reg;

  // divider: a restart realigns the phase so the first period is whole
  always_comb begin
    divCount_next = divCount_reg + DIV_ONE;
    tick_next = 1'b0;
    if (tk.restart) begin
      divCount_next = DIV_ZERO;
    end else if (divCount_reg >= limit - DIV_ONE) begin
      // coarse or fine period ends here
      divCount_next = DIV_ZERO;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divCount_reg <= DIV_ZERO;
      tick_reg <= 1'b0;
    end else begin
      divCount_reg <= divCount_next;
      tick_reg <= tick_next;
    end
  end

  // helper: cycles between ticks, valid only over an undisturbed period
  logic [DIV_W-1:0] gap_reg;
  logic clean_reg, coarseSeen_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_reg <= DIV_ZERO;
      clean_reg <= 1'b0;
      coarseSeen_reg <= 1'b0;
    end else begin
      coarseSeen_reg <= tk.coarse;
      gap_reg <= (tick_reg || tk.restart) ? DIV_ZERO : gap_reg + DIV_ONE;
      clean_reg <= tk.restart || (tk.coarse != coarseSeen_reg) ? 1'b0 :
                   (tick_reg ? 1'b1 : clean_reg);
    end
  end

  coarse_period_a: assert property (@(posedge clk) disable iff (!reset_n)
    tick_reg && clean_reg && tk.coarse && coarseSeen_reg |->
      gap_reg == DIV_W'(COARSE_CYCLES - 1))
    else $error("coarse tick spacing wrong");
  fine_period_a: assert property (@(posedge clk) disable iff (!reset_n)
    tick_reg && clean_reg && !tk.coarse && !coarseSeen_reg |->
      gap_reg == DIV_W'(FINE_TICK_CYCLES - 1))
    else $error("fine tick spacing wrong");
endmodule

// >>> core/hibernation_wake_timer.sv
// Notes on behaviour
// - non-zero preload write reloads the counter and restarts counting, even mid-count
// - zero preload write disables counting and suppresses the wake event
// - resolution bit one: each decrement is one eighth of a second
// - resolution bit zero: each decrement is one 30.5 us slow-clock period
// - live count readable at offset 08h, writes there ignored
// - preload, control, count decoded at 00h, 04h, 08h from the fixed base
// - decrementing to zero raises the wake event output
// - reset returns counter logic and all registers to defaults
`timescale 1ns/1ps
module hibernation_wake_timer
  import wake_timer_pkg::*;
#(
  parameter int COARSE_CYCLES = COARSE_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // controller register port
  input wire logic [31:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [31:0] busWrData,
  output logic [31:0] busRdData,
  output logic busAck,
  // resolution select, shown in the control register
  input wire logic coarseSelect,
  // wake event toward the interrupt aggregator
  output logic wakeEventOut
);
  // register address match against the fixed base
  function automatic logic regHit(input logic [31:0] addr, input logic [31:0] ofs);
    regHit = (addr == BLOCK_BASE + ofs);
  endfunction

  tick_if tk ();

  tick_prescaler #(
    .COARSE_CYCLES(COARSE_CYCLES)
  ) u_prescaler (
    .clk(clk),
    .reset_n(reset_n),
    .tk(tk)
  );

  timer_state_t state_reg, state_next;
  logic [CNT_W-1:0] preload_reg, preload_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic coarse_reg;
  logic wake_reg, wake_next;
  logic [31:0] rdData_reg, rdData_next;
  logic ack_reg, ack_next;
  logic preloadWr;
  logic [CNT_W-1:0] wrValue;

  assign preloadWr = busWrite && regHit(busAddr, OFS_PRELOAD);
  assign wrValue = busWrData[CNT_W-1:0];
  assign tk.restart = preloadWr;
  assign tk.coarse = coarse_reg;

  assign busRdData = rdData_reg;
  assign busAck = ack_reg;
  assign wakeEventOut = wake_reg;

  // counter and preload next state
  always_comb begin
    state_next = state_reg;
    preload_next = preload_reg;
    count_next = count_reg;
    wake_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        count_next = count_reg;
      end
      ST_RUN: begin
        if (tk.tick) begin
          count_next = count_reg - COUNT_ONE;
          if (count_reg == COUNT_ONE) begin
            wake_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // a write overrides a coincident tick: firmware intent wins
    if (preloadWr) begin
      preload_next = wrValue;
      wake_next = 1'b0;
      if (wrValue != COUNT_ZERO) begin
        count_next = wrValue;
        state_next = ST_RUN;
      end else begin
        count_next = COUNT_ZERO;
        state_next = ST_IDLE;
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rdData_next = RD_ZERO;
    // every access is acknowledged in the next cycle, never stalled
    ack_next = busWrite || busRead;
    if (busRead) begin
      if (regHit(busAddr, OFS_PRELOAD)) begin
        rdData_next[CNT_W-1:0] = preload_reg;
      end else if (regHit(busAddr, OFS_CONTROL)) begin
        rdData_next[CTRL_COARSE_BIT] = coarse_reg;
      end else if (regHit(busAddr, OFS_COUNT)) begin
        rdData_next[CNT_W-1:0] = count_reg;
      end
    end
  end

  // all state returns to defaults under reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      preload_reg <= PRELOAD_RESET;
      count_reg <= COUNT_RESET;
      coarse_reg <= 1'b0;
      wake_reg <= 1'b0;
      rdData_reg <= RD_ZERO;
      ack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      preload_reg <= preload_next;
      count_reg <= count_next;
      coarse_reg <= coarseSelect;
      wake_reg <= wake_next;
      rdData_reg <= rdData_next;
      ack_reg <= ack_next;
    end
  end

  // checks
  sequence nonzeroLoad;
    preloadWr && (wrValue != COUNT_ZERO);
  endsequence
  sequence zeroLoad;
    preloadWr && (wrValue == COUNT_ZERO);
  endsequence
  sequence lastTick;
    state_reg == ST_RUN && tk.tick && count_reg == COUNT_ONE && !preloadWr;
  endsequence

  preload_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
    nonzeroLoad |=> count_reg == $past(wrValue) && state_reg == ST_RUN)
    else $error("non-zero preload did not reload");
  zero_disable_a: assert property (@(posedge clk) disable iff (!reset_n)
    zeroLoad |=> (state_reg == ST_IDLE && !wake_reg && count_reg == COUNT_ZERO)
      ##1 (!wake_reg || $past(preloadWr)))
    else $error("zero preload did not disable");
  count_readback_a: assert property (@(posedge clk) disable iff (!reset_n)
    busRead && regHit(busAddr, OFS_COUNT) |=>
      busRdData == {16'h0000, $past(count_reg)})
    else $error("count readback mismatch");
  control_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
    busRead && regHit(busAddr, OFS_CONTROL) |=>
      busRdData == {31'h0000_0000, $past(coarse_reg)})
    else $error("control register decode wrong");
  write_nostall_a: assert property (@(posedge clk) disable iff (!reset_n)
    busWrite |=> busAck && (!$past(preloadWr) || preload_reg == $past(wrValue)))
    else $error("write not acknowledged in one cycle");
  wake_on_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    lastTick |=> wakeEventOut && count_reg == COUNT_ZERO ##1 !wakeEventOut)
    else $error("wake missing at zero");
  reset_default_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> count_reg == COUNT_RESET && !wakeEventOut && !busAck
      && preload_reg == PRELOAD_RESET && state_reg == ST_IDLE)
    else $error("state not at default after reset");
  hold_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_IDLE && !preloadWr |=> count_reg == $past(count_reg) && !wakeEventOut
      || $past(wake_reg) == 1'b0 && count_reg == $past(count_reg))
    else $error("idle counter moved");
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import wake_timer_pkg::*;
  // coarse tick shortened so coarse runs stay short
  localparam int CC = 40;
  localparam int FL = 3050;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] busAddr = 32'h0;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [31:0] busWrData = 32'h0;
  logic [31:0] busRdData;
  logic busAck;
  logic coarseSelect = 1'b1;
  logic wakeEventOut;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h244a;
  logic [31:0] rd;
  int cyc;
  int n;
  // reference model: preload, count, tick phase and wake, kept from the rules
  int mPre = 0;
  int mCnt = 0;
  int mPh = 0;
  int mCo = 0;
  bit mWake = 1'b0;
  // expected read data, queued at the edge that takes the read
  int rdQ[$];

  // 100 MHz clock
  always #5 clk = ~clk;

  hibernation_wake_timer #(.COARSE_CYCLES(CC)) hibernation_wake_timer_inst (
    .clk(clk), .reset_n(reset_n), .busAddr(busAddr), .busWrite(busWrite),
    .busRead(busRead), .busWrData(busWrData), .busRdData(busRdData),
    .busAck(busAck), .coarseSelect(coarseSelect), .wakeEventOut(wakeEventOut));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // model steps on the design's edges; wake is compared every cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mPre = 0;
      mCnt = 0;
      mPh = 0;
      mCo = 0;
      mWake = 1'b0;
      rdQ.delete();
    end else begin
      if (busRead) begin
        if (busAddr == BLOCK_BASE + OFS_PRELOAD) begin
          rdQ.push_back(mPre);
        end else if (busAddr == BLOCK_BASE + OFS_CONTROL) begin
          rdQ.push_back(mCo);
        end else if (busAddr == BLOCK_BASE + OFS_COUNT) begin
          rdQ.push_back(mCnt);
        end else begin
          rdQ.push_back(0);
        end
      end
      chk("wakeModel", {31'h0, mWake}, {31'h0, wakeEventOut});
      mWake = 1'b0;
      // a preload write realigns the tick phase, so the first decrement is one cycle late
      if (busWrite && busAddr == BLOCK_BASE + OFS_PRELOAD) begin
        mPre = int'(busWrData[15:0]);
        mCnt = mPre;
        mPh = -1;
      end else if (mCnt > 0) begin
        mPh++;
        if (mPh == (mCo ? CC : FL)) begin
          mPh = 0;
          mCnt--;
          mWake = (mCnt == 0);
        end
      end
      mCo = coarseSelect;
    end
  end

  // one access; ack and data stand in the cycle after the taking edge
  task automatic bus(input logic wr, input logic [31:0] ofs, input logic [31:0] d);
    @(posedge clk);
    busWrite <= wr;
    busRead <= !wr;
    busAddr <= BLOCK_BASE + ofs;
    busWrData <= d;
    @(posedge clk);
    busWrite <= 1'b0;
    busRead <= 1'b0;
    #1;
    chk("busAck", 32'h1, {31'h0, busAck});
    rd = busRdData;
    if (!wr) begin
      chk("rdModel", rdQ.pop_front(), rd);
    end
  endtask

  task automatic rdchk(input string nm, input logic [31:0] ofs, input logic [31:0] e);
    bus(1'b0, ofs, 32'h0);
    chk(nm, e, rd);
  endtask

  // upper write bits are random junk that must be ignored
  task automatic pre(input int v);
    seed = lfsr(seed);
    bus(1'b1, OFS_PRELOAD, {seed[31:16], v[15:0]});
  endtask

  // bounded wait for the wake pulse, cycles counted in cyc
  task automatic wwake(input int lim);
    cyc = 0;
    while (cyc < lim && wakeEventOut !== 1'b1) begin
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask

  // prescaler phase is loose by a couple of cycles, hence the window
  task automatic wchk(input int k, input int l);
    wwake(k * l + 20);
    chk("wakeInWindow", 32'h1, {31'h0, (cyc >= k * l - 2 && cyc <= k * l + 4)});
  endtask

  // hang guard, well above the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rdchk("preload", OFS_PRELOAD, 32'h0);
    rdchk("count", OFS_COUNT, 32'h0);
    rdchk("unmapped", 32'h0000_0010, 32'h0);
    bus(1'b1, OFS_COUNT, 32'h0000_ffff);
    rdchk("countRo", OFS_COUNT, 32'h0);
    bus(1'b1, OFS_CONTROL, 32'h0);
    rdchk("control", OFS_CONTROL, 32'h1);
    // coarse run of random length
    seed = lfsr(seed);
    n = 2 + int'(seed[1:0]);
    pre(n);
    wchk(n, CC);
    rdchk("countHeld", OFS_COUNT, 32'h0);
    rdchk("preloadBack", OFS_PRELOAD, mPre);
    wwake(200);
    chk("noRewake", 32'd200, cyc);
    // reload in mid count
    pre(5);
    repeat (100) @(posedge clk);
    rdchk("countMid", OFS_COUNT, 32'h3);
    pre(2);
    wchk(2, CC);
    // zero write stops the count
    pre(4);
    repeat (50) @(posedge clk);
    pre(0);
    rdchk("countStop", OFS_COUNT, 32'h0);
    wwake(300);
    chk("noWakeStop", 32'd300, cyc);
    // fine resolution
    @(posedge clk);
    coarseSelect <= 1'b0;
    rdchk("controlFine", OFS_CONTROL, 32'h0);
    pre(2);
    wchk(2, FL);
    // reset in mid count
    @(posedge clk);
    coarseSelect <= 1'b1;
    pre(3);
    repeat (20) @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdchk("countRst", OFS_COUNT, 32'h0);
    rdchk("preloadRst", OFS_PRELOAD, 32'h0);
    wwake(300);
    chk("noWakeRst", 32'd300, cyc);
    end_sim();
  end
endmodule
